/* core/hssd_shutdown_ctrl.sv */
// Shutdown configuration register and fault reaction for four high-side switches.
`timescale 1ns/10ps
`include "hssd_defines.svh"
module hssd_shutdown_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire hssd_pkg::hssd_mode_e dev_mode,
  input wire hssd_pkg::hssd_fault_s fault,
  input wire logic [3:0] sw_request,
  output logic [3:0] sw_enable
);
  logic [15:0] hs_fault_shutdown_config;
  logic [15:0] next_config;
  logic [3:0] ov_cut;
  logic [3:0] ot_cut;
  logic uv_cut;
  logic ot_any;

  function automatic logic [15:0] hssd_masked(input logic [15:0] v, input logic [15:0] m);
    hssd_masked = v & m;
  endfunction : hssd_masked

  always_comb begin
    next_config = hs_fault_shutdown_config;
    if (soft_reset) begin
      next_config = `HSSD_RESET;
    end else if (restart) begin
      next_config = hssd_masked(hs_fault_shutdown_config, `HSSD_RESTART_KEEP);
    end else if (reg_wr && reg_addr == `HSSD_ADDR) begin
      next_config = hssd_masked(reg_wdata, `HSSD_WRITE_MASK);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_fault_shutdown_config <= `HSSD_RESET;
    end else begin
      hs_fault_shutdown_config <= next_config;
    end
  end

  // Read data is registered; bits 4 and 2..0 are never stored, so they read zero.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `HSSD_RESET;
    end else if (reg_addr == `HSSD_ADDR) begin
      reg_rdata <= hs_fault_shutdown_config;
    end else begin
      reg_rdata <= `HSSD_RESET;
    end
  end

  assign ot_any = |fault.overtemp;
  assign uv_cut = fault.undervolt && !hs_fault_shutdown_config[`HSSD_UV_SD_BIT];

  always_comb begin
    for (int i = 0; i < `HSSD_NUM_SW; i++) begin
      if (dev_mode == hssd_pkg::HSSD_MODE_NORMAL) begin
        ov_cut[i] = fault.overvolt && !hs_fault_shutdown_config[`HSSD_OV_NSD_LSB + i];
      end else begin
        ov_cut[i] = fault.overvolt && !hs_fault_shutdown_config[`HSSD_OV_LPSD_BIT];
      end
      if (hs_fault_shutdown_config[`HSSD_OT_SCOPE_BIT]) begin
        ot_cut[i] = fault.overtemp[i];
      end else begin
        ot_cut[i] = ot_any;
      end
    end
  end

  for (genvar g = 0; g < `HSSD_NUM_SW; g++) begin : g_sw
    hssd_switch_gate u_gate (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .ov_cut(ov_cut[g]),
      .uv_cut(uv_cut),
      .ot_cut(ot_cut[g]),
      .ov_active(fault.overvolt),
      .uv_active(fault.undervolt),
      .ov_recover(hs_fault_shutdown_config[`HSSD_OV_REC_LSB + g]),
      .uv_recover(hs_fault_shutdown_config[`HSSD_UV_REC_BIT]),
      .sw_request(sw_request[g]),
      .sw_enable(sw_enable[g])
    );
  end
endmodule : hssd_shutdown_ctrl

/* include/hssd_defines.svh */
// Constants of the high-side switch fault shutdown configuration block.
`ifndef HSSD_DEFINES_SVH
`define HSSD_DEFINES_SVH
`define HSSD_ADDR 7'h07
`define HSSD_RESET 16'h0000
`define HSSD_WRITE_MASK 16'hFFE8
`define HSSD_RESTART_KEEP 16'hFFE8
`define HSSD_OV_REC_LSB 12
`define HSSD_OT_SCOPE_BIT 11
`define HSSD_OV_NSD_LSB 7
`define HSSD_OV_LPSD_BIT 6
`define HSSD_UV_SD_BIT 5
`define HSSD_UV_REC_BIT 3
`define HSSD_NUM_SW 4
`endif

/* include/hssd_pkg.sv */
// Types of the high-side switch fault shutdown configuration block.
package hssd_pkg;
  typedef enum logic [2:0] {
    HSSD_MODE_NORMAL = 3'b001,
    HSSD_MODE_STOP = 3'b010,
    HSSD_MODE_SLEEP = 3'b100
  } hssd_mode_e;
  typedef struct packed {
    logic overvolt;
    logic undervolt;
    logic [3:0] overtemp;
  } hssd_fault_s;
endpackage : hssd_pkg

/* core/hssd_switch_gate.sv */
// Per-switch gate that tracks supply faults and decides whether a switch may conduct.
`timescale 1ns/10ps
`include "hssd_defines.svh"
module hssd_switch_gate (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ov_cut,
  input wire logic uv_cut,
  input wire logic ot_cut,
  input wire logic ov_active,
  input wire logic uv_active,
  input wire logic ov_recover,
  input wire logic uv_recover,
  input wire logic sw_request,
  output logic sw_enable
);
  logic ov_latched;
  logic uv_latched;
  // Latched cut stays until the fault has cleared and recovery is allowed; a switch
  // without recovery stays off until software drops and re-issues its request.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ov_latched <= 1'b0;
    end else if (ov_cut) begin
      ov_latched <= 1'b1;
    end else if (!ov_active && (ov_recover || !sw_request)) begin
      ov_latched <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_latched <= 1'b0;
    end else if (uv_cut) begin
      uv_latched <= 1'b1;
    end else if (!uv_active && (uv_recover || !sw_request)) begin
      uv_latched <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_enable <= 1'b0;
    end else begin
      sw_enable <= sw_request && !ov_latched && !uv_latched && !ot_cut && !ov_cut && !uv_cut;
    end
  end
endmodule : hssd_switch_gate

/* test/hssd_asserts.sv */
// Checker of the shutdown configuration block.
`timescale 1ns/10ps
module hssd_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire hssd_pkg::hssd_mode_e dev_mode,
  input wire hssd_pkg::hssd_fault_s fault,
  input wire logic [3:0] sw_request,
  input wire logic [3:0] sw_enable
);
  logic [15:0] cfg;
  // Shadow copy, so the fault checks know the setting they depend on.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cfg <= 16'h0000;
    else if (soft_reset) cfg <= 16'h0000;
    else if (!restart && reg_wr && reg_addr == 7'h07) cfg <= reg_wdata & 16'hffe8;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_rd; reg_addr == 7'h07 |=> reg_rdata == $past(cfg); endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_ro; reg_rdata[4] == 1'b0 && reg_rdata[2:0] == 3'h0; endproperty
  a_ro: assert property (p_ro) else $error("bit 4 set");
  property p_ovn; dev_mode[0] && fault.overvolt && !cfg[7] |=> !sw_enable[0]; endproperty
  a_ovn: assert property (p_ovn) else $error("no cut");
  property p_ovs; !dev_mode[0] && fault.overvolt && !cfg[6] |=> sw_enable == 4'h0; endproperty
  a_ovs: assert property (p_ovs) else $error("no cut");
  property p_uv; fault.undervolt && !cfg[5] |=> sw_enable == 4'h0; endproperty
  a_uv: assert property (p_uv) else $error("no cut");
  property p_ot; fault.overtemp[1] && !cfg[11] |=> sw_enable == 4'h0; endproperty
  a_ot: assert property (p_ot) else $error("no cut");
  property p_ovr; $fell(fault.overvolt) && cfg[12] && sw_request[0] |-> ##[1:3] sw_enable[0];
  endproperty
  a_ovr: assert property (p_ovr) else $error("no recovery");
  property p_uvr; $fell(fault.undervolt) && cfg[3] && sw_request[0] |-> ##[1:3] sw_enable[0];
  endproperty
  a_uvr: assert property (p_uvr) else $error("no recovery");
endmodule : hssd_asserts
bind hssd_shutdown_ctrl hssd_asserts chk (.*);

/* test/test_hssd_shutdown_ctrl.sv */
// Self-checking bench of the shutdown configuration block.
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
  $display("FAIL %0t %h %h", $time, a, e); end end
module test_hssd_shutdown_ctrl;
  logic sys_clk = 0, reset_n = 0, soft_reset = 0, restart = 0, reg_wr = 0;
  logic [6:0] reg_addr = 7'h07;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  hssd_pkg::hssd_mode_e dev_mode = hssd_pkg::HSSD_MODE_NORMAL;
  hssd_pkg::hssd_fault_s fault = 6'h00;
  logic [3:0] sw_request = 4'h0, sw_enable;
  int num_errors = 0, n_compared = 0;
  always #2 sys_clk = ~sys_clk;
  hssd_shutdown_ctrl dut (.*);
  task wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= 7'h07;
  endtask : wr
  task rd(input logic [15:0] e);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
  endtask : rd
  // Requests drop at the end so a latched cut is cleared for the next case.
  task flt(input logic [15:0] c, input logic [2:0] m, input logic [5:0] f,
    input logic [3:0] e1, input logic [3:0] e2);
    wr(7'h07, c);
    dev_mode <= hssd_pkg::hssd_mode_e'(m);
    sw_request <= 4'hf;
    repeat (3) @(posedge sys_clk);
    fault <= f;
    rd(c & 16'hffe8);
    `CHK(sw_enable, e1)
    @(posedge sys_clk);
    fault <= 6'h00;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(sw_enable, e2)
    @(posedge sys_clk);
    sw_request <= 4'h0;
    repeat (2) @(posedge sys_clk);
  endtask : flt
  task give_verdict();
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(16'h0000);
    wr(7'h07, 16'hffff);
    wr(7'h06, 16'h0000);
    rd(16'hffe8);
    @(posedge sys_clk);
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
    rd(16'hffe8);
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    rd(16'h0000);
    flt(16'h0000, 3'h1, 6'h20, 4'h0, 4'h0);
    flt(16'h0700, 3'h1, 6'h20, 4'he, 4'he);
    flt(16'hf000, 3'h1, 6'h20, 4'h0, 4'hf);
    flt(16'h0000, 3'h2, 6'h20, 4'h0, 4'h0);
    flt(16'h0040, 3'h4, 6'h20, 4'hf, 4'hf);
    flt(16'h0000, 3'h1, 6'h10, 4'h0, 4'h0);
    flt(16'h0020, 3'h1, 6'h10, 4'hf, 4'hf);
    flt(16'h0008, 3'h1, 6'h10, 4'h0, 4'hf);
    flt(16'h0000, 3'h1, 6'h02, 4'h0, 4'hf);
    flt(16'h0800, 3'h1, 6'h02, 4'hd, 4'hf);
    give_verdict();
  end
endmodule : test_hssd_shutdown_ctrl
